// *** design/ohci_irq_events.sv ***
`timescale 1ns/1ps
module ohci_irq_events
  import ohci_irq_pkg::*;
#(
  parameter bit HAS_SMI_PIN = 1'b1
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic soft_reset,
  input wire reg_req_type reg_req,
  output logic [31:0] reg_rdata,
  input wire events_type events,
  output logic host_irq,
  output logic sys_mgmt_irq,
  output logic sof_token,
  output logic processing_halt,
  output logic done_queue_update_allowed,
  output logic [1:0] overrun_count
);

  // Decodes a write to one register offset.
  function automatic logic hit(input reg_req_type req, input logic [7:0] offset);
    hit = req.wr && (req.addr == offset);
  endfunction : hit

  logic [31:0] flags_q; // Sticky event flags.
  logic [31:0] flags_d; // Next value of the flags.
  logic [31:0] enable_q; // Set-only enable register.
  logic [31:0] enable_d; // Next value of the enables.
  logic [1:0] overrun_q; // Wrapping overrun counter.
  logic [1:0] overrun_d; // Next counter value.
  logic msb_q; // Last seen frame counter top bit.
  logic resume_q; // Last seen resume signaling level.
  logic owner_req_q; // Last seen ownership request level.
  logic fno_pend_q; // Frame overflow waiting for shared copy update.
  logic fno_pend_d; // Next value of the overflow pending bit.
  logic so_pend_q; // Overrun waiting for shared copy update.
  logic so_pend_d; // Next value of the overrun pending bit.
  logic halt_q; // Processing stopped after a fatal error.
  logic irq_q; // Registered host interrupt.
  logic smi_q; // Registered management interrupt.
  logic sof_q; // Start-of-frame token strobe.
  logic [31:0] rdata_q; // Registered read data.
  logic [31:0] rdata_d; // Read data selected this cycle.

  wire flags_wr = hit(reg_req, EVENT_FLAGS_OFFSET); // Write to the flag register.
  wire enable_wr = hit(reg_req, ENABLE_MASK_OFFSET); // Write to the enable register.
  wire [31:0] clear_bits = flags_wr ? (reg_req.wdata & EVENT_FLAGS_IMPL) : 32'h0000_0000;
  wire [31:0] set_enables = enable_wr ? (reg_req.wdata & ENABLE_MASK_IMPL) : 32'h0000_0000;

  // Edge detection on level sources; all inputs are synchronous to ref_clk.
  wire owner_rise = events.owner_change_request && !owner_req_q;
  wire msb_toggle = events.frame_msb != msb_q;
  wire resume_rise = events.resume_signal && !resume_q && !events.resume_by_software;
  wire fno_event = (msb_toggle || fno_pend_q) && events.frame_shared_updated;
  wire so_event = (events.schedule_overrun || so_pend_q) && events.frame_shared_updated;

  // Per-source set vector in register layout.
  logic [31:0] set_bits;
  always_comb begin
    set_bits = 32'h0000_0000;
    set_bits[OWNER_CHANGE_BIT] = owner_rise && HAS_SMI_PIN;
    set_bits[ROOT_HUB_BIT] = events.root_hub_changed;
    set_bits[FRAME_OVERFLOW_BIT] = fno_event;
    set_bits[FATAL_ERROR_BIT] = events.system_error;
    set_bits[RESUME_BIT] = resume_rise;
    set_bits[FRAME_START_BIT] = events.frame_start;
    set_bits[DONE_QUEUE_BIT] = events.done_queue_head_written;
    set_bits[OVERRUN_BIT] = so_event;
  end

  // A set in the same cycle as a clear wins, so no event is lost.
  assign flags_d = ((flags_q & ~clear_bits) | set_bits) & EVENT_FLAGS_IMPL;
  assign enable_d = enable_q | set_enables;
  assign overrun_d = events.schedule_overrun ? overrun_q + 2'h1 : overrun_q;
  // An overflow or overrun seen before the shared copy is written waits for it.
  assign fno_pend_d = (msb_toggle || fno_pend_q) && !events.frame_shared_updated;
  assign so_pend_d = (events.schedule_overrun || so_pend_q) && !events.frame_shared_updated;

  // Reads have no side effect; unmapped offsets return zero.
  assign rdata_d = !reg_req.rd ? rdata_q :
                   (reg_req.addr == EVENT_FLAGS_OFFSET) ? flags_q :
                   (reg_req.addr == ENABLE_MASK_OFFSET) ? enable_q : 32'h0000_0000;

  // Interrupt conditions; ownership change goes to the management line only.
  wire [31:0] pending = flags_q & enable_q;
  wire irq_cond = enable_q[MASTER_ENABLE_BIT] && (|pending[ROOT_HUB_BIT:OVERRUN_BIT]);
  wire smi_cond = pending[OWNER_CHANGE_BIT] && HAS_SMI_PIN;

  // Register state; soft_reset returns everything to its reset value.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_q <= EVENT_FLAGS_RESET;
      enable_q <= ENABLE_MASK_RESET;
      overrun_q <= OVERRUN_COUNT_RESET;
      fno_pend_q <= 1'b0;
      so_pend_q <= 1'b0;
      halt_q <= 1'b0;
    end else if (soft_reset) begin
      flags_q <= EVENT_FLAGS_RESET;
      enable_q <= ENABLE_MASK_RESET;
      overrun_q <= OVERRUN_COUNT_RESET;
      fno_pend_q <= 1'b0;
      so_pend_q <= 1'b0;
      halt_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      enable_q <= enable_d;
      overrun_q <= overrun_d;
      fno_pend_q <= fno_pend_d;
      so_pend_q <= so_pend_d;
      halt_q <= halt_q || events.system_error;
    end
  end

  // Edge history and output flops; of these only irq_q and smi_q are forced low by soft reset, so
  // that a level already high at soft reset does not fake a fresh edge.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      msb_q <= 1'b0;
      resume_q <= 1'b0;
      owner_req_q <= 1'b0;
      irq_q <= 1'b0;
      smi_q <= 1'b0;
      sof_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      msb_q <= events.frame_msb;
      resume_q <= events.resume_signal;
      owner_req_q <= events.owner_change_request;
      irq_q <= irq_cond && !soft_reset;
      smi_q <= smi_cond && !soft_reset;
      sof_q <= events.frame_start;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign host_irq = irq_q;
  assign sys_mgmt_irq = smi_q;
  assign sof_token = sof_q;
  assign processing_halt = halt_q;
  assign overrun_count = overrun_q;
  // The next head writeback waits until software has cleared the flag.
  assign done_queue_update_allowed = !flags_q[DONE_QUEUE_BIT];

  // Ownership request edge sets the flag at the next edge when the pin exists.
  property p_owner_set;
    @(posedge ref_clk) disable iff (!reset_n)
    (owner_rise && !soft_reset) |=> flags_q[OWNER_CHANGE_BIT] == HAS_SMI_PIN;
  endproperty
  a_owner_set: assert property (p_owner_set) else $error("owner change flag wrong after request");
  // The management interrupt follows an enabled owner change by one cycle.
  property p_smi;
    @(posedge ref_clk) disable iff (!reset_n)
    (smi_cond && !soft_reset) |=> sys_mgmt_irq;
  endproperty
  a_smi: assert property (p_smi) else $error("management interrupt missing");
  // Without the pin the owner flag never reads one.
  property p_no_pin;
    @(posedge ref_clk) disable iff (!reset_n)
    !HAS_SMI_PIN |-> !flags_q[OWNER_CHANGE_BIT];
  endproperty
  a_no_pin: assert property (p_no_pin) else $error("owner flag set without pin");
  // A system error halts processing until a reset.
  property p_halt;
    @(posedge ref_clk) disable iff (!reset_n)
    (events.system_error && !soft_reset) |=> processing_halt && flags_q[FATAL_ERROR_BIT];
  endproperty
  a_halt: assert property (p_halt) else $error("halt or fatal flag missing");
  // Software-caused resume never sets the resume flag.
  property p_sw_resume;
    @(posedge ref_clk) disable iff (!reset_n)
    (!flags_q[RESUME_BIT] && events.resume_by_software) |=> !flags_q[RESUME_BIT];
  endproperty
  a_sw_resume: assert property (p_sw_resume) else $error("resume flag set by software resume");
  // Writeback blocks further updates while the flag holds.
  property p_done_hold;
    @(posedge ref_clk) disable iff (!reset_n)
    (events.done_queue_head_written && !soft_reset) |=> !done_queue_update_allowed;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done head update not held");
  // Host interrupt matches the enabled-flag condition one cycle later.
  property p_irq;
    @(posedge ref_clk) disable iff (!reset_n || soft_reset)
    ##1 host_irq == $past(irq_cond);
  endproperty
  a_irq: assert property (p_irq) else $error("host interrupt level mismatch");
  // Enable bits never fall except by reset.
  property p_enable_sticky;
    @(posedge ref_clk) disable iff (!reset_n)
    !soft_reset |=> ((enable_q & $past(enable_q)) == $past(enable_q));
  endproperty
  a_enable_sticky: assert property (p_enable_sticky) else $error("enable bit fell");
  // Flags fall only on a write of one or a reset.
  property p_flag_clear;
    @(posedge ref_clk) disable iff (!reset_n)
    (!flags_wr && !soft_reset) |=> ((flags_q & $past(flags_q)) == $past(flags_q));
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag cleared without write");
  // Each overrun advances the counter by exactly one, wrapping.
  property p_count;
    @(posedge ref_clk) disable iff (!reset_n)
    (events.schedule_overrun && !soft_reset) |=> overrun_count == $past(overrun_q) + 2'h1;
  endproperty
  a_count: assert property (p_count) else $error("overrun count step wrong");

  // The frame start token and its flag appear at the same edge.
  property p_sof_token;
    @(posedge ref_clk) disable iff (!reset_n)
    (events.frame_start && !soft_reset) |=> sof_token && flags_q[FRAME_START_BIT];
  endproperty
  a_sof_token: assert property (p_sof_token) else $error("frame start token or flag missing");
  // A root hub or port change latches its flag.
  property p_root_hub;
    @(posedge ref_clk) disable iff (!reset_n)
    (events.root_hub_changed && !soft_reset) |=> flags_q[ROOT_HUB_BIT];
  endproperty
  a_root_hub: assert property (p_root_hub) else $error("root hub flag missing");
  // A device resume edge latches the resume flag.
  property p_resume_edge;
    @(posedge ref_clk) disable iff (!reset_n)
    (resume_rise && !soft_reset) |=> flags_q[RESUME_BIT];
  endproperty
  a_resume_edge: assert property (p_resume_edge) else $error("resume flag missing");
  // An overflow seen at the shared copy update latches its flag.
  property p_overflow;
    @(posedge ref_clk) disable iff (!reset_n)
    (fno_event && !soft_reset) |=> flags_q[FRAME_OVERFLOW_BIT];
  endproperty
  a_overflow: assert property (p_overflow) else $error("frame overflow flag missing");
  // An overrun seen at the shared copy update latches its flag.
  property p_overrun_flag;
    @(posedge ref_clk) disable iff (!reset_n)
    (so_event && !soft_reset) |=> flags_q[OVERRUN_BIT];
  endproperty
  a_overrun_flag: assert property (p_overrun_flag) else $error("overrun flag missing");
  // Every implemented bit written as one reads back set.
  property p_enable_write;
    @(posedge ref_clk) disable iff (!reset_n)
    (enable_wr && !soft_reset) |=> ((enable_q & $past(set_enables)) == $past(set_enables));
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable bit not set by write");
  // A write of one clears its flag unless an event sets it in the same cycle.
  property p_clear_write;
    @(posedge ref_clk) disable iff (!reset_n)
    (flags_wr && !soft_reset) |=> ((flags_q & $past(clear_bits) & ~$past(set_bits)) == 32'h0000_0000);
  endproperty
  a_clear_write: assert property (p_clear_write) else $error("flag not cleared by write");
  // The halt stays until a reset; software cannot lift it by a write.
  property p_halt_hold;
    @(posedge ref_clk) disable iff (!reset_n)
    (processing_halt && !soft_reset) |=> processing_halt;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt released without reset");
  // Without the master enable no host interrupt follows.
  property p_irq_mask;
    @(posedge ref_clk) disable iff (!reset_n)
    !enable_q[MASTER_ENABLE_BIT] |=> !host_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("host interrupt without master enable");
  // A read of the enable register returns its contents one cycle later.
  property p_read_enable;
    @(posedge ref_clk) disable iff (!reset_n)
    (reg_req.rd && (reg_req.addr == ENABLE_MASK_OFFSET)) |=> reg_rdata == $past(enable_q);
  endproperty
  a_read_enable: assert property (p_read_enable) else $error("enable read data wrong");

  c_irq: cover property (@(posedge ref_clk) disable iff (!reset_n) host_irq ##1 !host_irq);
  c_wrap: cover property (@(posedge ref_clk) disable iff (!reset_n) overrun_q == 2'h3 ##1 overrun_q == 2'h0);
  c_smi: cover property (@(posedge ref_clk) disable iff (!reset_n) $rose(sys_mgmt_irq));
  // A fatal error and a software resume are both worth seeing once.
  c_halt: cover property (@(posedge ref_clk) disable iff (!reset_n) $rose(processing_halt));
  c_sw_resume: cover property (@(posedge ref_clk) disable iff (!reset_n) events.resume_by_software);

endmodule : ohci_irq_events

// *** include/ohci_irq_pkg.sv ***
package ohci_irq_pkg;

  // Register offsets inside the operational register space.
  localparam logic [7:0] EVENT_FLAGS_OFFSET = 8'h0C;
  localparam logic [7:0] ENABLE_MASK_OFFSET = 8'h10;

  // Field positions shared by the flag and enable registers; the master enable bit is in the enable register only.
  localparam int OVERRUN_BIT = 0;
  localparam int DONE_QUEUE_BIT = 1;
  localparam int FRAME_START_BIT = 2;
  localparam int RESUME_BIT = 3;
  localparam int FATAL_ERROR_BIT = 4;
  localparam int FRAME_OVERFLOW_BIT = 5;
  localparam int ROOT_HUB_BIT = 6;
  localparam int OWNER_CHANGE_BIT = 30;
  localparam int MASTER_ENABLE_BIT = 31;

  // Reset values of both registers and of the overrun counter.
  localparam logic [31:0] EVENT_FLAGS_RESET = 32'h0000_0000;
  localparam logic [31:0] ENABLE_MASK_RESET = 32'h0000_0000;
  localparam logic [1:0] OVERRUN_COUNT_RESET = 2'h0;

  // Bits that really exist; every other position reads as zero.
  localparam logic [31:0] EVENT_FLAGS_IMPL = 32'h4000_007F;
  localparam logic [31:0] ENABLE_MASK_IMPL = 32'hC000_007F;

  // One register access, presented for a single cycle.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_type;

  // Event sources from the rest of the host controller.
  typedef struct packed {
    logic owner_change_request;
    logic root_hub_changed;
    logic frame_msb;
    logic frame_shared_updated;
    logic system_error;
    logic resume_signal;
    logic resume_by_software;
    logic frame_start;
    logic done_queue_head_written;
    logic schedule_overrun;
  } events_type;

endpackage : ohci_irq_pkg

// *** verification/host_model.sv ***
`timescale 1ns/1ps
// Host driver model: one strobed word access at a time, launched just after an edge.
module host_model
  import ohci_irq_pkg::*;
(
  input wire logic ref_clk,
  output reg_req_type reg_req,
  input wire logic [31:0] reg_rdata
);
  // The port starts idle so no access is seen during reset.
  initial reg_req = '0;
  // One write; the strobe is held across exactly one sampling edge, then one idle edge
  // passes so that a following access never reassigns the strobe in the same time step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_req.addr = a;
    reg_req.wdata = d & ENABLE_MASK_IMPL;
    reg_req.wr = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_req.wr = 1'b0;
    // Idle data is inverted so a stale word can never be mistaken for new data.
    reg_req.wdata = ~reg_req.wdata;
    @(posedge ref_clk);
    #1;
  endtask : wr
  // One read; the registered answer is settled just after the taking edge.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_req.addr = a;
    reg_req.rd = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_req.rd = 1'b0;
    d = reg_rdata;
    @(posedge ref_clk);
    #1;
  endtask : rd
endmodule : host_model

// *** verification/ohci_interrupt_status_enable_bench.sv ***
`timescale 1ns/1ps
module ohci_interrupt_status_enable_bench;
  import ohci_irq_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic soft_reset = 1'b0;
  reg_req_type reg_req;
  logic [31:0] reg_rdata;
  logic [31:0] v;
  events_type events = '0;
  logic host_irq;
  logic sys_mgmt_irq;
  logic sof_token;
  logic processing_halt;
  logic dq_ok;
  logic [1:0] overrun_count;
  int err_total = 0;
  int checked = 0;
  // Free-running 50 MHz clock.
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  ohci_irq_events i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .soft_reset(soft_reset), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .events(events), .host_irq(host_irq), .sys_mgmt_irq(sys_mgmt_irq),
    .sof_token(sof_token), .processing_halt(processing_halt), .done_queue_update_allowed(dq_ok),
    .overrun_count(overrun_count));
  host_model i_host (.ref_clk(ref_clk), .reg_req(reg_req), .reg_rdata(reg_rdata));
  // Compares with case equality so an unknown never counts as a match.
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Advances n edges and lands just after the last one.
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  // One-cycle event pulse; bit order follows the packed event struct.
  task automatic pulse(input logic [9:0] e);
    events = events | e;
    tick(1);
    events = events & ~e;
  endtask : pulse
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  // The flag register and overrun count start cleared; a zero write must not clear enables.
  task automatic t_enable();
    i_host.rd(EVENT_FLAGS_OFFSET, v);
    chk("flags reset", v, EVENT_FLAGS_RESET);
    chk("count reset", {30'h0, overrun_count}, 32'h0);
    i_host.wr(ENABLE_MASK_OFFSET, 32'h8000_0004);
    i_host.wr(ENABLE_MASK_OFFSET, 32'h0);
    i_host.rd(ENABLE_MASK_OFFSET, v);
    chk("enable set", v, 32'h8000_0004);
    i_host.rd(ENABLE_MASK_OFFSET, v);
    chk("enable reread", v, 32'h8000_0004);
    i_host.rd(8'h20, v);
    chk("unmapped", v, 32'h0);
  endtask : t_enable
  // Frame start raises the token and the level interrupt; only a one clears it.
  task automatic t_sof();
    pulse(10'h004);
    chk("sof token", sof_token, 1'b1);
    tick(1);
    chk("irq up", host_irq, 1'b1);
    i_host.wr(EVENT_FLAGS_OFFSET, 32'h0);
    chk("irq held", host_irq, 1'b1);
    i_host.wr(EVENT_FLAGS_OFFSET, 32'h4);
    tick(1);
    chk("irq down", host_irq, 1'b0);
  endtask : t_sof
  // Masked events latch without interrupting; fatal error halts until reset.
  task automatic t_events();
    // Root hub change, system error and head writeback land together.
    pulse(10'h122);
    i_host.rd(EVENT_FLAGS_OFFSET, v);
    chk("flags", v, 32'h52);
    chk("irq masked", host_irq, 1'b0);
    chk("halt", processing_halt, 1'b1);
    chk("dq hold", dq_ok, 1'b0);
    i_host.wr(EVENT_FLAGS_OFFSET, 32'h2);
    chk("dq free", dq_ok, 1'b1);
    // The halt is only lifted by way of a controller reset.
    soft_reset = 1'b1;
    tick(1);
    soft_reset = 1'b0;
    chk("halt off", processing_halt, 1'b0);
    i_host.rd(EVENT_FLAGS_OFFSET, v);
    chk("flags clr", v, 32'h0);
  endtask : t_events
  // Software-made resume is ignored, a device resume edge is latched.
  task automatic t_resume();
    events = events | 10'h018;
    tick(2);
    i_host.rd(EVENT_FLAGS_OFFSET, v);
    chk("sw resume", v, 32'h0);
    events = '0;
    tick(1);
    events.resume_signal = 1'b1;
    tick(2);
    i_host.rd(EVENT_FLAGS_OFFSET, v);
    chk("dev resume", v, 32'h8);
    events.resume_signal = 1'b0;
    i_host.wr(EVENT_FLAGS_OFFSET, 32'h8);
  endtask : t_resume
  // Overrun counts at once and wraps; its flag and overflow follow the shared update.
  task automatic t_frame();
    pulse(10'h001);
    tick(1);
    pulse(10'h040);
    i_host.rd(EVENT_FLAGS_OFFSET, v);
    chk("overrun", v, 32'h1);
    chk("count 1", {30'h0, overrun_count}, 32'h1);
    repeat (4) begin
      pulse(10'h001);
      tick(1);
    end
    chk("count wrap", {30'h0, overrun_count}, 32'h1);
    events.frame_msb = 1'b1;
    tick(1);
    pulse(10'h040);
    i_host.rd(EVENT_FLAGS_OFFSET, v);
    chk("overflow", v, 32'h21);
  endtask : t_frame
  // Ownership change goes to the management interrupt, not the host one.
  task automatic t_owner();
    i_host.wr(ENABLE_MASK_OFFSET, 32'h4000_0000);
    events.owner_change_request = 1'b1;
    tick(2);
    chk("smi", sys_mgmt_irq, 1'b1);
    chk("no host irq", host_irq, 1'b0);
    i_host.rd(EVENT_FLAGS_OFFSET, v);
    chk("owner flag", v, 32'h4000_0021);
    events.owner_change_request = 1'b0;
    i_host.wr(EVENT_FLAGS_OFFSET, 32'h4000_0000);
    tick(1);
    chk("smi off", sys_mgmt_irq, 1'b0);
  endtask : t_owner
  // Main sequence: reset for four cycles, then the scenarios in turn.
  initial begin
    repeat (4) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    chk("dq reset", dq_ok, 1'b1);
    t_enable();
    t_sof();
    t_events();
    t_resume();
    t_frame();
    t_owner();
    finish_test();
  end
  // Guard against a hang: running out counts as a mismatch.
  initial begin
    #200000;
    err_total++;
    finish_test();
  end
endmodule : ohci_interrupt_status_enable_bench
